// File: design/adcr_regmap.sv
// Register map of the multichannel converter behind its serial command interface.
`timescale 1ns/1ps
module adcr_regmap
    import adcr_pkg::*;
#(
    parameter logic [7:0] ID_VALUE = 8'hA5  // Identity byte; the value is arbitrary.
) (
    // Clock and reset.
    input  wire logic        ref_clk_i,
    input  wire logic        resetn_i,
    // Serial pins.
    input  wire logic        sclk_i,
    input  wire logic        din_i,
    input  wire logic        cs_n_i,
    output logic             dout_o,
    // Converter side.
    input  wire logic [23:0] result_i,
    input  wire logic        result_load_i,
    input  wire logic [23:0] error_event_i,
    input  wire logic [7:0]  mclk_count_i,
    input  wire logic [3:0]  current_channel_index_i,
    output logic [15:0]      converter_control_o,
    output logic [15:0]      channel_enable_o
);
`include "adcr_map.svh"

    adcr_ser_if ser ();

    // Front end owns every asynchronous pin.
    adcr_serial_fe u_fe (
        .ref_clk_i (ref_clk_i),
        .resetn_i  (resetn_i),
        .sclk_i    (sclk_i),
        .din_i     (din_i),
        .cs_n_i    (cs_n_i),
        .ser       (ser)
    );

    // Serial state.
    adcr_phase_t phase, next_phase;
    logic [4:0]  bitcnt, next_bitcnt;     // Bits taken in this phase.
    logic [23:0] sh_in, next_sh_in;       // Incoming bits, newest in bit 0.
    logic [23:0] sh_out, next_sh_out;     // Outgoing bits, next one in bit 23.
    logic [5:0]  addr, next_addr;         // Target register select.
    logic [4:0]  width, next_width;       // Length of the data phase.
    // Register storage.
    logic [15:0] ctrl, next_ctrl;
    logic [23:0] io1, next_io1;
    logic [15:0] io2, next_io2;
    logic [23:0] erren, next_erren;
    logic [23:0] errs, next_errs;         // Sticky error flags.
    logic [23:0] data, next_data;
    logic [7:0]  mclk, next_mclk;
    logic        rdy, next_rdy;
    logic        por, next_por;
    logic [15:0] ch [16], next_ch [16];
    logic [15:0] cfg [8], next_cfg [8];
    logic [23:0] flt [8], next_flt [8];
    logic [23:0] ofs [8], next_ofs [8];
    logic [23:0] gn [8], next_gn [8];
    // Helpers.
    logic [7:0]  status;                  // Status byte as read.
    logic [7:0]  cmd_byte;                // Command byte on its last bit.
    logic [23:0] wr_word;                 // Data word on its last bit.
    logic [23:0] rd_word;                 // Value of the selected register.
    logic [4:0]  rd_width;                // Width of the selected register.

    // Bit five of the status byte is a fixed zero.
    assign status   = {rdy, |errs, 1'b0, por, current_channel_index_i};
    assign cmd_byte = {sh_in[6:0], ser.din_bit};
    assign wr_word  = {sh_in[22:0], ser.din_bit};

    // Decode the address in the command byte into a value and a width.
    always_comb begin
        rd_word  = 24'h000000;
        rd_width = `ADCR_W8;
        if (cmd_byte[5:0] == `ADCR_A_STATUS) begin
            rd_word = {16'h0000, status};
        end else if (cmd_byte[5:0] == `ADCR_A_CTRL) begin
            rd_word  = {8'h00, ctrl};
            rd_width = `ADCR_W16;
        end else if (cmd_byte[5:0] == `ADCR_A_DATA) begin
            rd_word  = data;
            rd_width = `ADCR_W24;
        end else if (cmd_byte[5:0] == `ADCR_A_IO1) begin
            rd_word  = io1;
            rd_width = `ADCR_W24;
        end else if (cmd_byte[5:0] == `ADCR_A_IO2) begin
            rd_word  = {8'h00, io2};
            rd_width = `ADCR_W16;
        end else if (cmd_byte[5:0] == `ADCR_A_ID) begin
            rd_word = {16'h0000, ID_VALUE};
        end else if (cmd_byte[5:0] == `ADCR_A_ERR) begin
            rd_word  = errs;
            rd_width = `ADCR_W24;
        end else if (cmd_byte[5:0] == `ADCR_A_ERREN) begin
            rd_word  = erren;
            rd_width = `ADCR_W24;
        end else if (cmd_byte[5:0] == `ADCR_A_MCLK) begin
            rd_word = {16'h0000, mclk};
        end else if (cmd_byte[5:0] <= `ADCR_A_CH15) begin
            rd_word  = {8'h00, ch[4'(cmd_byte[5:0] - `ADCR_A_CH0)]};
            rd_width = `ADCR_W16;
        end else if (cmd_byte[5:0] <= `ADCR_A_CFG7) begin
            rd_word  = {8'h00, cfg[3'(cmd_byte[5:0] - `ADCR_A_CFG0)]};
            rd_width = `ADCR_W16;
        end else if (cmd_byte[5:0] <= `ADCR_A_FLT7) begin
            rd_word  = flt[3'(cmd_byte[5:0] - `ADCR_A_FLT0)];
            rd_width = `ADCR_W24;
        end else if (cmd_byte[5:0] <= `ADCR_A_OFS7) begin
            rd_word  = ofs[3'(cmd_byte[5:0] - `ADCR_A_OFS0)];
            rd_width = `ADCR_W24;
        end else if (cmd_byte[5:0] <= `ADCR_A_LAST) begin
            rd_word  = gn[3'(cmd_byte[5:0] - `ADCR_A_GAIN0)];
            rd_width = `ADCR_W24;
        end
        // Addresses past the map read as one zero byte.
    end

    // Next values of the serial engine and of every register.
    always_comb begin
        next_phase = phase;
        next_bitcnt = bitcnt;
        next_sh_in = sh_in;
        next_sh_out = sh_out;
        next_addr = addr;
        next_width = width;
        next_ctrl = ctrl;
        next_io1 = io1;
        next_io2 = io2;
        next_erren = erren;
        next_errs = errs;
        next_mclk = mclk_count_i;
        next_rdy = rdy;
        next_por = por;
        next_data = data;
        next_ch = ch;
        next_cfg = cfg;
        next_flt = flt;
        next_ofs = ofs;
        next_gn = gn;
        // Read-clear side effects are applied first so that new events below win.
        if (!ser.sel) begin
            // Deselect abandons any half-done transfer.
            next_phase  = ADCR_PH_CMD;
            next_bitcnt = 5'h00;
        end else if (ser.sclk_rise) begin
            next_sh_in  = wr_word;
            next_bitcnt = bitcnt + 5'h01;
            case (phase)
                ADCR_PH_CMD: begin
                    if (bitcnt == 5'h00 && ser.din_bit) begin
                        next_bitcnt = 5'h00;
                    end else if (bitcnt == `ADCR_CMD_LAST) begin
                        next_bitcnt = 5'h00;
                        next_addr   = cmd_byte[5:0];
                        next_width  = rd_width;
                        if (cmd_byte[`ADCR_CMD_RW]) begin
                            // Align the value so its top bit leaves first.
                            next_phase  = ADCR_PH_RD;
                            next_sh_out = rd_word << (5'(`ADCR_W24 - rd_width));
                            if (cmd_byte[5:0] == `ADCR_A_STATUS) begin
                                next_por = 1'b0;
                            end
                            if (cmd_byte[5:0] == `ADCR_A_DATA) begin
                                next_rdy = 1'b1;
                            end
                            if (cmd_byte[5:0] == `ADCR_A_ERR) begin
                                next_errs = 24'h000000;
                            end
                        end else if (cmd_byte[5:0] != `ADCR_A_STATUS) begin
                            next_phase = ADCR_PH_WR;
                        end
                    end
                end
                ADCR_PH_WR: begin
                    if (bitcnt == width - 5'h01) begin
                        next_phase  = ADCR_PH_CMD;
                        next_bitcnt = 5'h00;
                        // Read-only and unmapped targets fall through untouched.
                        if (addr == `ADCR_A_CTRL) begin
                            next_ctrl = wr_word[15:0];
                        end else if (addr == `ADCR_A_IO1) begin
                            next_io1 = wr_word;
                        end else if (addr == `ADCR_A_IO2) begin
                            next_io2 = wr_word[15:0];
                        end else if (addr == `ADCR_A_ERREN) begin
                            next_erren = wr_word;
                        end else if (addr >= `ADCR_A_CH0 && addr <= `ADCR_A_CH15) begin
                            next_ch[4'(addr - `ADCR_A_CH0)] = wr_word[15:0];
                        end else if (addr >= `ADCR_A_CFG0 && addr <= `ADCR_A_CFG7) begin
                            next_cfg[3'(addr - `ADCR_A_CFG0)] = wr_word[15:0];
                        end else if (addr >= `ADCR_A_FLT0 && addr <= `ADCR_A_FLT7) begin
                            next_flt[3'(addr - `ADCR_A_FLT0)] = wr_word;
                        end else if (addr >= `ADCR_A_OFS0 && addr <= `ADCR_A_OFS7) begin
                            next_ofs[3'(addr - `ADCR_A_OFS0)] = wr_word;
                        end else if (addr >= `ADCR_A_GAIN0 && addr <= `ADCR_A_LAST) begin
                            next_gn[3'(addr - `ADCR_A_GAIN0)] = wr_word;
                        end
                    end
                end
                ADCR_PH_RD: begin
                    if (bitcnt == width - 5'h01) begin
                        next_phase  = ADCR_PH_CMD;
                        next_bitcnt = 5'h00;
                    end
                end
                default: begin
                    next_phase  = ADCR_PH_CMD;
                    next_bitcnt = 5'h00;
                end
            endcase
        end else if (ser.sclk_fall && phase == ADCR_PH_RD && bitcnt != 5'h00) begin
            // The first fall of a read keeps the top bit, since the host has not sampled it yet.
            next_sh_out = {sh_out[22:0], 1'b0};
        end
        // Enabled error events set their flags even during a clearing read.
        next_errs = next_errs | (error_event_i & erren);
        // A fresh result clears the ready bit even if a data read sets it.
        if (result_load_i) begin
            next_data = result_i;
            next_rdy  = 1'b0;
        end
        // The long run of ones returns every register except mclk to its reset value.
        if (ser.soft_rst) begin
            next_phase = ADCR_PH_CMD;
            next_bitcnt = 5'h00;
            next_sh_out = 24'h000000;
            next_ctrl = `ADCR_R_CTRL;
            next_io1 = `ADCR_R_IO1;
            next_io2 = `ADCR_R_IO2;
            next_erren = `ADCR_R_ERREN;
            next_errs = 24'h000000;
            next_data = `ADCR_R_DATA;
            next_rdy = 1'b0;
            next_por = 1'b1;
            for (int i = 0; i < 16; i++) begin
                next_ch[i] = (i == 0) ? `ADCR_R_CH0 : `ADCR_R_CHN;
            end
            for (int i = 0; i < 8; i++) begin
                next_cfg[i] = `ADCR_R_CFG;
                next_flt[i] = `ADCR_R_FLT;
                next_ofs[i] = `ADCR_R_OFS;
                next_gn[i] = `ADCR_R_GAIN;
            end
        end
    end

    // Register every group; power-on reset also loads sh_in, addr, width and mclk, which the soft reset leaves alone.
    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            phase <= ADCR_PH_CMD;
            bitcnt <= 5'h00;
            sh_in <= 24'h000000;
            sh_out <= 24'h000000;
            addr <= `ADCR_A_STATUS;
            width <= `ADCR_W8;
            ctrl <= `ADCR_R_CTRL;
            io1 <= `ADCR_R_IO1;
            io2 <= `ADCR_R_IO2;
            erren <= `ADCR_R_ERREN;
            errs <= 24'h000000;
            data <= `ADCR_R_DATA;
            mclk <= `ADCR_R_BYTE;
            rdy <= 1'b0;
            por <= 1'b1;
            for (int i = 0; i < 16; i++) begin
                ch[i] <= (i == 0) ? `ADCR_R_CH0 : `ADCR_R_CHN;
            end
            for (int i = 0; i < 8; i++) begin
                cfg[i] <= `ADCR_R_CFG;
                flt[i] <= `ADCR_R_FLT;
                ofs[i] <= `ADCR_R_OFS;
                gn[i] <= `ADCR_R_GAIN;
            end
        end else begin
            phase <= next_phase;
            bitcnt <= next_bitcnt;
            sh_in <= next_sh_in;
            sh_out <= next_sh_out;
            addr <= next_addr;
            width <= next_width;
            ctrl <= next_ctrl;
            io1 <= next_io1;
            io2 <= next_io2;
            erren <= next_erren;
            errs <= next_errs;
            data <= next_data;
            mclk <= next_mclk;
            rdy <= next_rdy;
            por <= next_por;
            ch <= next_ch;
            cfg <= next_cfg;
            flt <= next_flt;
            ofs <= next_ofs;
            gn <= next_gn;
        end
    end

    // Outputs are flop values; enables are gathered bit by bit.
    assign dout_o              = sh_out[23];
    assign converter_control_o = ctrl;
    for (genvar g = 0; g < 16; g++) begin : g_en
        assign channel_enable_o[g] = ch[g][`ADCR_CH_EN];
    end

    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!resetn_i);

    chk_cmd_stall: assert property (
        (ser.sel && ser.sclk_rise && !ser.soft_rst && phase == ADCR_PH_CMD && bitcnt == 5'h00 && ser.din_bit)
        |=> (phase == ADCR_PH_CMD && bitcnt == 5'h00)) else $error("Leading one did not stall the command.");
    chk_soft_reset_regs: assert property (
        ser.soft_rst |=> (ch[0] == `ADCR_R_CH0 && ch[15] == `ADCR_R_CHN && channel_enable_o == 16'h0001))
        else $error("Channel registers not reset.");
    chk_soft_reset_phase: assert property (
        ser.soft_rst |=> (phase == ADCR_PH_CMD && bitcnt == 5'h00 && ctrl == `ADCR_R_CTRL))
        else $error("Long high run did not reset the interface.");
    chk_offset_reset: assert property (
        ser.soft_rst |=> (ofs[0] == `ADCR_R_OFS && ofs[7] == `ADCR_R_OFS)) else $error("Offset not mid-scale.");
    chk_result_hold: assert property (
        (!result_load_i && !ser.soft_rst) |=> $stable(data)) else $error("Read-only data changed.");
    chk_status_zero: assert property (status[5] == 1'b0) else $error("Fixed zero bit set.");
    chk_read_start: assert property (
        (ser.sel && ser.sclk_rise && !ser.soft_rst && phase == ADCR_PH_CMD && bitcnt == `ADCR_CMD_LAST
         && cmd_byte[`ADCR_CMD_RW]) |=> phase == ADCR_PH_RD) else $error("Read command not taken.");
    chk_read_end: assert property (
        (ser.sel && ser.sclk_rise && !ser.soft_rst && phase == ADCR_PH_RD && bitcnt == width - 5'h01)
        |=> (phase == ADCR_PH_CMD && bitcnt == 5'h00)) else $error("Interface did not return to command.");
    chk_status_read: assert property (
        (phase == ADCR_PH_CMD && next_phase == ADCR_PH_RD && next_addr == `ADCR_A_STATUS && !ser.soft_rst)
        |=> (sh_out[23:16] == $past(status) && width == `ADCR_W8)) else $error("Address zero read not status.");
    chk_rdy_clear: assert property (
        (result_load_i && !ser.soft_rst) |=> (!rdy && data == $past(result_i))) else $error("Ready not cleared.");

endmodule // adcr_regmap

// File: design/adcr_map.svh
// Offsets, field positions, reset values and counts of the converter register map.
`ifndef ADCR_MAP_SVH
`define ADCR_MAP_SVH

// Register addresses carried by the command byte.
`define ADCR_A_STATUS   6'h00
`define ADCR_A_CTRL     6'h01
`define ADCR_A_DATA     6'h02
`define ADCR_A_IO1      6'h03
`define ADCR_A_IO2      6'h04
`define ADCR_A_ID       6'h05
`define ADCR_A_ERR      6'h06
`define ADCR_A_ERREN    6'h07
`define ADCR_A_MCLK     6'h08
`define ADCR_A_CH0      6'h09
`define ADCR_A_CH15     6'h18
`define ADCR_A_CFG0     6'h19
`define ADCR_A_CFG7     6'h20
`define ADCR_A_FLT0     6'h21
`define ADCR_A_FLT7     6'h28
`define ADCR_A_OFS0     6'h29
`define ADCR_A_OFS7     6'h30
`define ADCR_A_GAIN0    6'h31
`define ADCR_A_LAST     6'h38

// Command byte fields.
`define ADCR_CMD_RW     6
`define ADCR_CMD_LAST   5'h07

// Status byte fields.
`define ADCR_ST_RDY     7
`define ADCR_ST_ERR     6
`define ADCR_ST_POR     4

// Channel register enable bit.
`define ADCR_CH_EN      15

// Reset values.
`define ADCR_R_CTRL     16'h0000
`define ADCR_R_IO1      24'h000000
`define ADCR_R_IO2      16'h0000
`define ADCR_R_ERREN    24'h000040
`define ADCR_R_CH0      16'h8001
`define ADCR_R_CHN      16'h0001
`define ADCR_R_CFG      16'h0860
`define ADCR_R_FLT      24'h060180
`define ADCR_R_OFS      24'h800000
`define ADCR_R_GAIN     24'h500000
`define ADCR_R_DATA     24'h000000
`define ADCR_R_BYTE     8'h00

// Transfer widths in bits.
`define ADCR_W8         5'h08
`define ADCR_W16        5'h10
`define ADCR_W24        5'h18

// Consecutive high data bits that force a full reset.
`define ADCR_RESET_ONES 7'h40

`endif

// File: design/adcr_pkg.sv
// Types shared by the converter register map modules.
package adcr_pkg;

    // Serial interface phase, one-hot.
    typedef enum logic [2:0] {
        ADCR_PH_CMD = 3'b001,
        ADCR_PH_WR  = 3'b010,
        ADCR_PH_RD  = 3'b100
    } adcr_phase_t;

endpackage

// File: design/adcr_ser_if.sv
// Carrier between the serial front end and the register core.
`timescale 1ns/1ps
interface adcr_ser_if;
    logic sclk_rise;   // One-cycle pulse on a serial clock rising edge.
    logic sclk_fall;   // One-cycle pulse on a serial clock falling edge.
    logic din_bit;     // Synchronised data input level.
    logic sel;         // Chip select is active.
    logic soft_rst;    // One-cycle pulse after the long run of high data bits.

    modport fe   (output sclk_rise, output sclk_fall, output din_bit, output sel, output soft_rst);
    modport core (input sclk_rise, input sclk_fall, input din_bit, input sel, input soft_rst);
endinterface

// File: design/adcr_serial_fe.sv
// Serial pin synchroniser, edge detector and long-run reset detector.
`timescale 1ns/1ps
module adcr_serial_fe
    import adcr_pkg::*;
(
    // Clock and reset.
    input  wire logic ref_clk_i,
    input  wire logic resetn_i,
    // Serial pins.
    input  wire logic sclk_i,
    input  wire logic din_i,
    input  wire logic cs_n_i,
    // Events toward the core.
    adcr_ser_if.fe    ser
);
`include "adcr_map.svh"

    logic [2:0] sclk_q;      // Two synchroniser stages plus one edge stage.
    logic [1:0] din_q;       // Data synchroniser.
    logic [1:0] csn_q;       // Chip select synchroniser.
    logic [6:0] ones_cnt;    // Run length of high data bits.
    logic [6:0] next_ones_cnt;
    logic       fire;        // The run reached its limit this edge.

    // Edges come from the second and third stages only, never the first.
    assign ser.sclk_rise = sclk_q[1] & ~sclk_q[2];
    assign ser.sclk_fall = ~sclk_q[1] & sclk_q[2];
    assign ser.din_bit   = din_q[1];
    assign ser.sel       = ~csn_q[1];

    // Count high bits; saturate so one long run resets only once.
    always_comb begin
        next_ones_cnt = ones_cnt;
        fire          = 1'b0;
        if (ser.sclk_rise && ser.sel) begin
            if (!din_q[1]) begin
                next_ones_cnt = 7'h00;
            end else if (ones_cnt != `ADCR_RESET_ONES) begin
                next_ones_cnt = ones_cnt + 7'h01;
                fire          = (ones_cnt == (`ADCR_RESET_ONES - 7'h01));
            end
        end
    end

    // Register the pins, the counter and the reset pulse.
    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            sclk_q       <= 3'h7;
            din_q        <= 2'h0;
            csn_q        <= 2'h3;
            ones_cnt     <= 7'h00;
            ser.soft_rst <= 1'b0;
        end else begin
            sclk_q       <= {sclk_q[1:0], sclk_i};
            din_q        <= {din_q[0], din_i};
            csn_q        <= {csn_q[0], cs_n_i};
            ones_cnt     <= next_ones_cnt;
            ser.soft_rst <= fire;
        end
    end

endmodule // adcr_serial_fe

// File: test/adcr_host.sv
// Host model that drives the serial command interface of the register map.
`timescale 1ns/1ps
module adcr_host (
    // Clock.
    input  wire logic ref_clk_i,
    // Serial pins.
    output logic      sclk_o,
    output logic      din_o,
    output logic      cs_n_o,
    input  wire logic dout_i
);
    // The serial clock idles high and the link starts deselected.
    initial begin
        sclk_o = 1'b1;
        din_o  = 1'b0;
        cs_n_o = 1'b1;
    end

    // Waits n clocks, then steps just past the edge.
    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk_i);
        #1;
    endtask

    // One bit; six clocks per half period leave the synchroniser ample margin.
    task automatic bit_x(input logic b, output logic r);
        sclk_o = 1'b0;
        din_o  = b;
        tick(6);
        sclk_o = 1'b1;
        r      = dout_i;
        tick(6);
    endtask

    // Leading ones, the command byte, then n data bits, all MSB first.
    task automatic xfer(input int ones, input logic [7:0] cmd, input int n,
                        input logic [23:0] wd, output logic [23:0] rd);
        logic r;
        cs_n_o = 1'b0;
        rd     = 24'h000000;
        tick(2);
        for (int i = 0; i < ones; i++) bit_x(1'b1, r);
        for (int i = 7; i >= 0; i--) bit_x(cmd[i], r);
        for (int i = n - 1; i >= 0; i--) begin
            bit_x(wd[i], r);
            rd = {rd[22:0], r};
        end
        tick(4);
        cs_n_o = 1'b1;
        din_o  = ~din_o;  // Released data line shows no stale value.
        tick(4);
    endtask

    // A frame cut short after k command bits; the device must drop it.
    task automatic cut(input logic [7:0] cmd, input int k);
        logic r;
        cs_n_o = 1'b0;
        tick(2);
        for (int i = 7; i > 7 - k; i--) bit_x(cmd[i], r);
        tick(4);
        cs_n_o = 1'b1;
        tick(4);
    endtask
endmodule  // adcr_host

// File: test/tb.sv
// Self-checking bench for the converter register map.
`timescale 1ns/1ps
`define CHK(nm, e, s) begin compares++; if ((s) !== (e)) begin error_cnt++; $display("MISMATCH %s exp %h got %h", nm, e, s); end end
module tb;
    localparam logic [7:0] ID_V = 8'h3C;  // Identity byte; the value is arbitrary.
    logic        ref_clk_i, resetn_i, sclk, din, cs_n, dout, ld;
    logic [23:0] res, ev, rd, v;
    logic [7:0]  mclk;
    logic [5:0]  a6;
    logic [5:0]  ro [4] = '{6'h02, 6'h05, 6'h06, 6'h08};
    logic [3:0]  chi;
    logic [15:0] ctl, chen;
    int          error_cnt, compares;

    adcr_regmap #(.ID_VALUE(ID_V)) i_dut (.ref_clk_i(ref_clk_i), .resetn_i(resetn_i), .sclk_i(sclk),
        .din_i(din), .cs_n_i(cs_n), .dout_o(dout), .result_i(res), .result_load_i(ld), .error_event_i(ev),
        .mclk_count_i(mclk), .current_channel_index_i(chi), .converter_control_o(ctl), .channel_enable_o(chen));
    adcr_host i_host (.ref_clk_i(ref_clk_i), .sclk_o(sclk), .din_o(din), .cs_n_o(cs_n), .dout_i(dout));

    // Transfer width; reads beyond the map return a single byte.
    function automatic int wid(input logic [5:0] a);
        if (a == 6'h00 || a == 6'h05 || a == 6'h08 || a > 6'h38) return 8;
        if (a == 6'h01 || a == 6'h04 || (a >= 6'h09 && a <= 6'h20)) return 16;
        return 24;
    endfunction

    // Value each register shows after any reset.
    function automatic logic [23:0] rstv(input logic [5:0] a);
        if (a == 6'h05) return {16'h0000, ID_V};
        if (a == 6'h07) return 24'h000040;
        if (a == 6'h08) return {16'h0000, mclk};
        if (a == 6'h09) return 24'h008001;
        if (a >= 6'h0A && a <= 6'h18) return 24'h000001;
        if (a >= 6'h19 && a <= 6'h20) return 24'h000860;
        if (a >= 6'h21 && a <= 6'h28) return 24'h060180;
        if (a >= 6'h29 && a <= 6'h30) return 24'h800000;
        if (a >= 6'h31 && a <= 6'h38) return 24'h500000;
        return 24'h000000;
    endfunction

    // One command and its data phase; a write to address zero has none.
    task automatic acc(input int ones, input logic rnw, input logic [5:0] a, input logic [23:0] wd);
        i_host.xfer(ones, {1'b0, rnw, a}, (!rnw && a == 6'h00) ? 0 : wid(a), wd, rd);
    endtask

    // Reads the status byte; hi holds ready, error, zero and reset flag.
    task automatic st(input logic [3:0] hi);
        acc(0, 1'b1, 6'h00, 24'h000000);
        `CHK("status", {hi, chi}, rd[7:0])
    endtask

    task automatic clk(input int n);
        repeat (n) @(posedge ref_clk_i);
        #1;
    endtask

    task automatic conclude();
        if (error_cnt == 0 && compares > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask

    initial begin
        ref_clk_i = 1'b0;
        forever #20 ref_clk_i = ~ref_clk_i;
    end

    // Cuts a hang short at about twice the expected run time.
    initial begin
        #3000000;
        error_cnt++;
        conclude();
    end

    initial begin
        void'($urandom(65));
        resetn_i = 1'b0;
        ld       = 1'b0;
        ev       = 24'h000000;
        res      = $urandom;
        mclk     = $urandom;
        chi      = $urandom;
        clk(10);
        resetn_i = 1'b1;
        clk(4);
        st(4'h1);
        st(4'h0);
        `CHK("ctl", 16'h0000, ctl)
        `CHK("chen", 16'h0001, chen)
        for (int a = 1; a <= 57; a++) begin
            acc(0, 1'b1, a[5:0], 24'h000000);
            `CHK("reset", rstv(a[5:0]), rd)
        end
        // Random data through IO2, offset and gain registers, some after stray leading ones.
        for (int k = 0; k < 12; k++) begin
            a6 = (k == 0) ? 6'h04 : 6'($urandom_range(41, 56));
            v  = $urandom;
            v  = (a6 == 6'h04) ? {8'h00, v[15:0]} : v;
            acc(k % 3, 1'b0, a6, v);
            acc(0, 1'b1, a6, 24'h000000);
            `CHK("rw", v, rd)
        end
        acc(0, 1'b0, 6'h00, 24'h000000);
        foreach (ro[i]) begin
            acc(0, 1'b0, ro[i], 24'hFFFFFF);
            acc(0, 1'b1, ro[i], 24'h000000);
            `CHK("ro", rstv(ro[i]), rd)
        end
        ld = 1'b1;
        clk(1);
        ld = 1'b0;
        st(4'h0);
        acc(0, 1'b1, 6'h02, 24'h000000);
        `CHK("data", res, rd)
        st(4'h8);
        // Only the enabled error bit may latch.
        ev = 24'h000041;
        clk(1);
        ev = 24'h000000;
        st(4'hC);
        acc(0, 1'b1, 6'h06, 24'h000000);
        `CHK("err", 24'h000040, rd)
        st(4'h8);
        acc(0, 1'b0, 6'h09, 24'h000001);
        acc(0, 1'b0, 6'h18, 24'h008001);
        acc(0, 1'b0, 6'h01, 24'h001234);
        `CHK("chen", 16'h8000, chen)
        `CHK("ctl", 16'h1234, ctl)
        // Half a read command, then deselect; the next command must parse from its first bit.
        i_host.cut(8'h41, 4);
        acc(0, 1'b1, 6'h01, 24'h000000);
        `CHK("cut", 24'h001234, rd)
        acc(64, 1'b1, 6'h01, 24'h000000);
        `CHK("soft", 24'h000000, rd)
        `CHK("chen", 16'h0001, chen)
        st(4'h1);
        conclude();
    end
endmodule  // tb
